// [hw/dspwm_pkg.sv]
package dspwm_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_CMP_A  = 8'h04;
  localparam logic [7:0] ADDR_CMP_B  = 8'h08;
  localparam logic [7:0] ADDR_CAP    = 8'h0C;
  localparam logic [7:0] ADDR_COUNT  = 8'h10;
  localparam logic [7:0] ADDR_FLAGS  = 8'h14;
  localparam logic [7:0] ADDR_PINS   = 8'h18;
  // Control register fields
  localparam int CTRL_WAVE_LSB  = 0;
  localparam int CTRL_MODE_A_LSB = 4;
  localparam int CTRL_MODE_B_LSB = 6;
  localparam int CTRL_PRESC_LSB = 8;
  // Flag register fields
  localparam int FLAG_OVF = 0;
  localparam int FLAG_CMPA = 1;
  localparam int FLAG_CMPB = 2;
  localparam int FLAG_CAP = 3;
  // Pin register fields
  localparam int PIN_DIR_A = 0;
  localparam int PIN_DIR_B = 1;
  localparam int PIN_EN_A  = 2;
  localparam int PIN_EN_B  = 3;
  // Waveform modes
  localparam logic [3:0] WAVE_PC8    = 4'h1;
  localparam logic [3:0] WAVE_PC9    = 4'h2;
  localparam logic [3:0] WAVE_PC10   = 4'h3;
  localparam logic [3:0] WAVE_PFC_CAP = 4'h8;
  localparam logic [3:0] WAVE_PFC_A  = 4'h9;
  localparam logic [3:0] WAVE_PC_CAP = 4'hA;
  localparam logic [3:0] WAVE_PC_A   = 4'hB;
  // Fixed tops and bottom
  localparam logic [15:0] TOP_8BIT  = 16'h00FF;
  localparam logic [15:0] TOP_9BIT  = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] BOTTOM    = 16'h0000;
  localparam logic [15:0] TOP_MIN   = 16'h0003;
  // Output modes
  localparam logic [1:0] OUT_NONINV = 2'h2;
  localparam logic [1:0] OUT_INV    = 2'h3;
  // Prescaler select codes and divisions
  localparam logic [2:0] PRESC_OFF = 3'h0;
  localparam logic [2:0] PRESC_1   = 3'h1;
  localparam logic [2:0] PRESC_8   = 3'h2;
  localparam logic [2:0] PRESC_64  = 3'h3;
  localparam logic [2:0] PRESC_256 = 3'h4;
  localparam logic [2:0] PRESC_1024 = 3'h5;
  localparam logic [9:0] DIV_8    = 10'h007;
  localparam logic [9:0] DIV_64   = 10'h03F;
  localparam logic [9:0] DIV_256  = 10'h0FF;
  localparam logic [9:0] DIV_1024 = 10'h3FF;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [hw/dspwm_tick_if.sv]
`timescale 1ns/1ns
interface dspwm_tick_if;
  logic [2:0] select;
  logic       tick;
  modport src (input select, output tick);
  modport dst (output select, input tick);
endinterface

// [hw/dspwm_presc.sv]
`timescale 1ns/1ns
module dspwm_presc (
  input wire logic   aclk,
  input wire logic   aresetn,
  dspwm_tick_if.src  tk
);
  typedef struct packed {
    logic [9:0] cnt;
    logic [2:0] sel;
  } dspwm_presc_s;
  dspwm_presc_s st_reg;
  dspwm_presc_s st_next;
  logic [9:0]   lim;

  always_comb begin
    unique case (tk.select)
      dspwm_pkg::PRESC_8:    lim = dspwm_pkg::DIV_8;
      dspwm_pkg::PRESC_64:   lim = dspwm_pkg::DIV_64;
      dspwm_pkg::PRESC_256:  lim = dspwm_pkg::DIV_256;
      dspwm_pkg::PRESC_1024: lim = dspwm_pkg::DIV_1024;
      default:               lim = 10'h000;
    endcase
  end

  // Divider restarts when the selection changes
  always_comb begin
    st_next     = st_reg;
    st_next.sel = tk.select;
    if (tk.select != st_reg.sel || st_reg.cnt >= lim) begin
      st_next.cnt = 10'h000;
    end else begin
      st_next.cnt = st_reg.cnt + 10'h001;
    end
  end

  // Tick is a one-cycle enable, never a clock
  assign tk.tick = (tk.select inside {[dspwm_pkg::PRESC_1:dspwm_pkg::PRESC_1024]})
                   && (tk.select == st_reg.sel) && (st_reg.cnt >= lim);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule // dspwm_presc

// [hw/dspwm_pwm_out.sv]
`timescale 1ns/1ns
module dspwm_pwm_out (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        tick,
  input  wire logic        dual_mode,
  input  wire logic        counting_up,
  input  wire logic [15:0] counter_value,
  input  wire logic [15:0] compare_value,
  input  wire logic [15:0] top_value,
  input  wire logic [1:0]  output_mode,
  input  wire logic        pin_direction_bit,
  input  wire logic        pin_enable,
  output logic             wave_level,
  output logic             pin_out,
  output logic             pin_oe
);
  typedef struct packed {
    logic wave;
  } dspwm_out_s;
  dspwm_out_s st_reg;
  dspwm_out_s st_next;
  logic       pwm_on;
  logic       level;

  assign pwm_on = dual_mode && output_mode[1];

  always_comb begin
    st_next = st_reg;
    level   = 1'b0;
    if (tick && pwm_on) begin
      if (compare_value == dspwm_pkg::BOTTOM) begin
        level = 1'b0;
      end else if (compare_value == top_value) begin
        level = 1'b1;
      end else if (counter_value == compare_value) begin
        level = !counting_up;
      end else begin
        level = (output_mode == dspwm_pkg::OUT_INV) ? !st_reg.wave : st_reg.wave;
      end
      st_next.wave = (output_mode == dspwm_pkg::OUT_INV) ? !level : level;
    end
  end

  assign wave_level = st_reg.wave;
  assign pin_out    = st_reg.wave;
  assign pin_oe     = pwm_on && pin_direction_bit && pin_enable;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule // dspwm_pwm_out

// [hw/dspwm_timer.sv]
// How it works
// - Counts zero up to TOP, back down.
// - Counter reverses at TOP on the next tick, no hold.
// - Phase correct: overflow flag at zero.
// - Phase correct: A/capture flag at TOP load.
// - Phase correct: compare buffers load at TOP.
// - Fixed TOP masks compare bits on write.
// - Output mode two normal, three inverted.
// - Pin driven only with direction and enable.
// - Non-inverted: clear on up match, set on down.
// - Tick prescaled by 1, 8, 64, 256, 1024.
// - Non-inverted: compare zero low, compare TOP high.
// - Modes 8 and 9 frequency correct.
// - Frequency correct TOP from 0x0003 to 16-bit.
// - Frequency correct: load and overflow at zero.
// - Frequency correct: A/capture flag at TOP.
// - Compare flag set on counter match.
// - Fully synchronous, tick is only an enable.
// - Modes 1, 2, 3, 10, 11 phase correct.
// - Modes 1, 2, 3 fixed TOP values.
`timescale 1ns/1ns
module dspwm_timer (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             wave_out_a,
  output logic             wave_out_a_oe,
  output logic             wave_out_b,
  output logic             wave_out_b_oe
);
  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [3:0]  waveform_mode;
    logic [1:0]  output_mode_a;
    logic [1:0]  output_mode_b;
    logic [2:0]  presc_sel;
    logic [3:0]  pin_bits;
    logic [15:0] cmp_a_buf;
    logic [15:0] cmp_b_buf;
    logic [15:0] compare_a_value;
    logic [15:0] compare_b_value;
    logic [15:0] capture_top_value;
    logic [15:0] counter_value;
    logic        counting_up;
    logic        overflow_flag;
    logic        compare_a_flag;
    logic        compare_b_flag;
    logic        capture_flag;
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } dspwm_timer_s;
  dspwm_timer_s st_reg;
  dspwm_timer_s st_next;

  dspwm_tick_if tk ();
  logic        tick;
  logic        phase_mode;
  logic        freq_mode;
  logic        dual_mode;
  logic        fixed_top;
  logic [15:0] top_value;
  logic [15:0] top_mask;
  logic        at_top;
  logic        at_bottom;
  logic        do_write;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic        wave_a_q;
  logic        wave_b_q;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  assign phase_mode = (st_reg.waveform_mode == dspwm_pkg::WAVE_PC8)
                   || (st_reg.waveform_mode == dspwm_pkg::WAVE_PC9)
                   || (st_reg.waveform_mode == dspwm_pkg::WAVE_PC10)
                   || (st_reg.waveform_mode == dspwm_pkg::WAVE_PC_CAP)
                   || (st_reg.waveform_mode == dspwm_pkg::WAVE_PC_A);
  assign freq_mode = (st_reg.waveform_mode == dspwm_pkg::WAVE_PFC_CAP)
                  || (st_reg.waveform_mode == dspwm_pkg::WAVE_PFC_A);
  assign dual_mode = phase_mode || freq_mode;

  always_comb begin
    fixed_top = 1'b1;
    unique case (st_reg.waveform_mode)
      dspwm_pkg::WAVE_PC8:  top_value = dspwm_pkg::TOP_8BIT;
      dspwm_pkg::WAVE_PC9:  top_value = dspwm_pkg::TOP_9BIT;
      dspwm_pkg::WAVE_PC10: top_value = dspwm_pkg::TOP_10BIT;
      dspwm_pkg::WAVE_PFC_A, dspwm_pkg::WAVE_PC_A: begin
        fixed_top = 1'b0;
        top_value = st_reg.compare_a_value;
      end
      default: begin
        fixed_top = 1'b0;
        top_value = st_reg.capture_top_value;
      end
    endcase
  end

  assign top_mask  = fixed_top ? top_value : 16'hFFFF;
  assign at_top    = st_reg.counter_value == top_value;
  assign at_bottom = st_reg.counter_value == dspwm_pkg::BOTTOM;

  dspwm_presc u_presc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tk      (tk.src)
  );
  assign tk.select = st_reg.presc_sel;
  assign tick      = tk.tick;

  ////////////////////////////////////////////////////////////////////////////
  // Bus write data
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{st_reg.w_strb[i]}};
    end
  end
  assign do_write = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_next = st_reg;
    wval    = 32'h0000_0000;
    // Write one to clear goes ahead of the events, so a same-cycle set wins
    if (do_write && st_reg.aw_addr == dspwm_pkg::ADDR_FLAGS) begin
      st_next.overflow_flag  = st_reg.overflow_flag
        & ~(st_reg.w_data[dspwm_pkg::FLAG_OVF] & wmask[dspwm_pkg::FLAG_OVF]);
      st_next.compare_a_flag = st_reg.compare_a_flag
        & ~(st_reg.w_data[dspwm_pkg::FLAG_CMPA] & wmask[dspwm_pkg::FLAG_CMPA]);
      st_next.compare_b_flag = st_reg.compare_b_flag
        & ~(st_reg.w_data[dspwm_pkg::FLAG_CMPB] & wmask[dspwm_pkg::FLAG_CMPB]);
      st_next.capture_flag   = st_reg.capture_flag
        & ~(st_reg.w_data[dspwm_pkg::FLAG_CAP] & wmask[dspwm_pkg::FLAG_CAP]);
    end
    // Counter and buffer loads
    if (tick && dual_mode) begin
      if (st_reg.counting_up) begin
        if (at_top) begin
          st_next.counting_up   = 1'b0;
          st_next.counter_value = st_reg.counter_value - 16'h0001;
        end else begin
          st_next.counter_value = st_reg.counter_value + 16'h0001;
        end
      end else begin
        if (at_bottom) begin
          st_next.counting_up   = 1'b1;
          st_next.counter_value = st_reg.counter_value + 16'h0001;
        end else begin
          st_next.counter_value = st_reg.counter_value - 16'h0001;
        end
      end
      if ((phase_mode && at_top) || (freq_mode && at_bottom)) begin
        st_next.compare_a_value = st_reg.cmp_a_buf & top_mask;
        st_next.compare_b_value = st_reg.cmp_b_buf & top_mask;
      end
      if (at_bottom) begin
        st_next.overflow_flag = 1'b1;
      end
      if (at_top) begin
        if (st_reg.waveform_mode == dspwm_pkg::WAVE_PC_A
            || st_reg.waveform_mode == dspwm_pkg::WAVE_PFC_A) begin
          st_next.compare_a_flag = 1'b1;
        end
        if (st_reg.waveform_mode == dspwm_pkg::WAVE_PC_CAP
            || st_reg.waveform_mode == dspwm_pkg::WAVE_PFC_CAP) begin
          st_next.capture_flag = 1'b1;
        end
      end
      if (st_reg.counter_value == st_reg.compare_a_value) begin
        st_next.compare_a_flag = 1'b1;
      end
      if (st_reg.counter_value == st_reg.compare_b_value) begin
        st_next.compare_b_flag = 1'b1;
      end
    end
    // Write address and data capture
    if (s_axi_awvalid && !st_reg.aw_held) begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.w_held) begin
      st_next.w_held = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      st_next.aw_held = 1'b0;
      st_next.w_held  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = dspwm_pkg::RESP_OKAY;
      unique case (st_reg.aw_addr)
        dspwm_pkg::ADDR_CTRL: begin
          wval = ({16'h0000, 5'h00, st_reg.presc_sel, st_reg.output_mode_b,
                   st_reg.output_mode_a, st_reg.waveform_mode} & ~wmask)
               | (st_reg.w_data & wmask);
          st_next.waveform_mode = wval[dspwm_pkg::CTRL_WAVE_LSB +: 4];
          st_next.output_mode_a = wval[dspwm_pkg::CTRL_MODE_A_LSB +: 2];
          st_next.output_mode_b = wval[dspwm_pkg::CTRL_MODE_B_LSB +: 2];
          st_next.presc_sel     = wval[dspwm_pkg::CTRL_PRESC_LSB +: 3];
        end
        dspwm_pkg::ADDR_CMP_A: begin
          wval = ({16'h0000, st_reg.cmp_a_buf} & ~wmask) | (st_reg.w_data & wmask);
          st_next.cmp_a_buf = wval[15:0] & top_mask;
        end
        dspwm_pkg::ADDR_CMP_B: begin
          wval = ({16'h0000, st_reg.cmp_b_buf} & ~wmask) | (st_reg.w_data & wmask);
          st_next.cmp_b_buf = wval[15:0] & top_mask;
        end
        dspwm_pkg::ADDR_CAP: begin
          wval = ({16'h0000, st_reg.capture_top_value} & ~wmask)
               | (st_reg.w_data & wmask);
          st_next.capture_top_value = wval[15:0];
        end
        dspwm_pkg::ADDR_COUNT: begin
          wval = ({16'h0000, st_reg.counter_value} & ~wmask) | (st_reg.w_data & wmask);
          st_next.counter_value = wval[15:0];
        end
        dspwm_pkg::ADDR_FLAGS: begin
          // Cleared ahead of the event logic above
          wval = st_reg.w_data & wmask;
        end
        dspwm_pkg::ADDR_PINS: begin
          wval = ({28'h0000000, st_reg.pin_bits} & ~wmask) | (st_reg.w_data & wmask);
          st_next.pin_bits = wval[3:0];
        end
        default: st_next.bresp = dspwm_pkg::RESP_SLVERR;
      endcase
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    // Read
    if (s_axi_arvalid && !st_reg.rvalid) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = dspwm_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        dspwm_pkg::ADDR_CTRL:  st_next.rdata = {16'h0000, 5'h00, st_reg.presc_sel,
                                 st_reg.output_mode_b, st_reg.output_mode_a,
                                 st_reg.waveform_mode};
        dspwm_pkg::ADDR_CMP_A: st_next.rdata = {16'h0000, st_reg.cmp_a_buf};
        dspwm_pkg::ADDR_CMP_B: st_next.rdata = {16'h0000, st_reg.cmp_b_buf};
        dspwm_pkg::ADDR_CAP:   st_next.rdata = {16'h0000, st_reg.capture_top_value};
        dspwm_pkg::ADDR_COUNT: st_next.rdata = {16'h0000, st_reg.counter_value};
        dspwm_pkg::ADDR_FLAGS: st_next.rdata = {28'h0000000, st_reg.capture_flag,
                                 st_reg.compare_b_flag, st_reg.compare_a_flag,
                                 st_reg.overflow_flag};
        dspwm_pkg::ADDR_PINS:  st_next.rdata = {28'h0000000, st_reg.pin_bits};
        default: begin
          st_next.rdata = 32'h0000_0000;
          st_next.rresp = dspwm_pkg::RESP_SLVERR;
        end
      endcase
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
  end

  assign s_axi_awready = !st_reg.aw_held;
  assign s_axi_wready  = !st_reg.w_held;
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign s_axi_rdata   = st_reg.rdata;
  assign s_axi_rresp   = st_reg.rresp;

  ////////////////////////////////////////////////////////////////////////////
  // Waveform channels
  dspwm_pwm_out u_out_a (
    .aclk              (aclk),
    .aresetn           (aresetn),
    .tick              (tick),
    .dual_mode         (dual_mode),
    .counting_up       (st_reg.counting_up),
    .counter_value     (st_reg.counter_value),
    .compare_value     (st_reg.compare_a_value),
    .top_value         (top_value),
    .output_mode       (st_reg.output_mode_a),
    .pin_direction_bit (st_reg.pin_bits[dspwm_pkg::PIN_DIR_A]),
    .pin_enable        (st_reg.pin_bits[dspwm_pkg::PIN_EN_A]),
    .wave_level        (wave_a_q),
    .pin_out           (wave_out_a),
    .pin_oe            (wave_out_a_oe)
  );

  dspwm_pwm_out u_out_b (
    .aclk              (aclk),
    .aresetn           (aresetn),
    .tick              (tick),
    .dual_mode         (dual_mode),
    .counting_up       (st_reg.counting_up),
    .counter_value     (st_reg.counter_value),
    .compare_value     (st_reg.compare_b_value),
    .top_value         (top_value),
    .output_mode       (st_reg.output_mode_b),
    .pin_direction_bit (st_reg.pin_bits[dspwm_pkg::PIN_DIR_B]),
    .pin_enable        (st_reg.pin_bits[dspwm_pkg::PIN_EN_B]),
    .wave_level        (wave_b_q),
    .pin_out           (wave_out_b),
    .pin_oe            (wave_out_b_oe)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg             <= '0;
      st_reg.counting_up <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule // dspwm_timer

// [tb/dspwm_load.sv]
`timescale 1ns/1ns
module dspwm_load (
  input  logic aclk,
  input  logic meas,
  input  logic wave_out_a,
  input  logic wave_out_a_oe,
  input  logic wave_out_b,
  input  logic wave_out_b_oe,
  output int   high_a,
  output int   high_b
);
  // Pin pulled low while not driven
  logic pin_a, pin_b;
  assign pin_a = wave_out_a_oe & wave_out_a;
  assign pin_b = wave_out_b_oe & wave_out_b;
  // High time over the window
  always_ff @(posedge aclk) begin
    high_a <= meas ? high_a + int'(pin_a) : 0;
    high_b <= meas ? high_b + int'(pin_b) : 0;
  end
endmodule // dspwm_load

// [tb/dspwm_timer_sva.sv]
`timescale 1ns/1ns
module dspwm_timer_sva (
  input logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input logic        s_axi_wready, s_axi_bvalid, s_axi_arvalid, s_axi_arready,
  input logic        s_axi_rvalid, wave_out_a, wave_out_a_oe, wave_out_b_oe,
  input logic [7:0]  s_axi_awaddr, s_axi_araddr,
  input logic [31:0] s_axi_wdata, s_axi_rdata,
  input logic [1:0]  s_axi_rresp
);
  logic [10:0] ctrl_reg, ctrl_q;
  logic [3:0]  pin_reg, pin_q;
  logic [15:0] cmpa_reg;
  logic [11:0] quiet_reg;
  logic        wr_hs, pc_run;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign pc_run = quiet_reg > 12'h44C && ctrl_reg[3:0] == dspwm_pkg::WAVE_PC8 &&
                  ctrl_reg[10:8] == dspwm_pkg::PRESC_1 && ctrl_reg[5] && wave_out_a_oe;
  function automatic logic gate(input logic [10:0] c, input logic m, dr, en);
    return m && dr && en && (c[3:0] inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB});
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg  <= '0;
      ctrl_q    <= '0;
      pin_reg   <= '0;
      pin_q     <= '0;
      cmpa_reg  <= '0;
      quiet_reg <= '0;
    end else begin
      ctrl_q    <= ctrl_reg;
      pin_q     <= pin_reg;
      quiet_reg <= wr_hs ? 12'h000 : quiet_reg + {11'h000, ~&quiet_reg};
      if (wr_hs && s_axi_awaddr == dspwm_pkg::ADDR_CTRL) ctrl_reg <= s_axi_wdata[10:0];
      if (wr_hs && s_axi_awaddr == dspwm_pkg::ADDR_PINS) pin_reg <= s_axi_wdata[3:0];
      if (wr_hs && s_axi_awaddr == dspwm_pkg::ADDR_CMP_A) cmpa_reg <= s_axi_wdata[15:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_wr_taken;
    wr_hs;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_wr_resp_time: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response not two cycles after taking");
  a_rd_resp_time: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read data not one cycle after address");
  a_rd_no_overlap: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  a_rd_bad_addr: assert property (s_rd_taken ##0 s_axi_araddr > 8'h18 |=>
    s_axi_rresp == dspwm_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_oe_a_gate: assert property (wave_out_a_oe |->
    gate(ctrl_reg, ctrl_reg[5], pin_reg[0], pin_reg[2]) ||
    gate(ctrl_q, ctrl_q[5], pin_q[0], pin_q[2])) else $error("pin a driven without gate");
  a_oe_b_gate: assert property (wave_out_b_oe |->
    gate(ctrl_reg, ctrl_reg[7], pin_reg[1], pin_reg[3]) ||
    gate(ctrl_q, ctrl_q[7], pin_q[1], pin_q[3])) else $error("pin b driven without gate");
  a_wave_cmp_zero: assert property (pc_run && cmpa_reg == 16'h0000 |->
    wave_out_a == ctrl_reg[4]) else $error("compare zero level wrong");
  a_wave_cmp_top: assert property (pc_run && cmpa_reg == dspwm_pkg::TOP_8BIT |->
    wave_out_a != ctrl_reg[4]) else $error("compare top level wrong");
endmodule // dspwm_timer_sva
bind dspwm_timer dspwm_timer_sva dspwm_timer_sva_i (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .wave_out_a(wave_out_a),
  .wave_out_a_oe(wave_out_a_oe), .wave_out_b_oe(wave_out_b_oe), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_araddr(s_axi_araddr), .s_axi_wdata(s_axi_wdata), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp));

// [tb/dspwm_timer_tb.sv]
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value at %0t: got %0h, expected %0h", $time, g, e); end end
module dspwm_timer_tb;
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic        meas = 1'b0, awready, wready, bvalid, arready, rvalid, wa, wa_oe, wb, wb_oe;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [1:0]  bresp, rresp, rs;
  logic [15:0] rnd = 16'h0063, v, ca, cb;
  int          err_total = 0, cmp_count = 0, cyc = 0, t_ar, t0, high_a, high_b, run, d, pd;
  int          dv [5] = '{1, 8, 64, 256, 1024};
  logic [3:0]  md [4] = '{4'h9, 4'hB, 4'h8, 4'hA};
  dspwm_timer dspwm_timer_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .wave_out_a(wa),
    .wave_out_a_oe(wa_oe), .wave_out_b(wb), .wave_out_b_oe(wb_oe));
  dspwm_load dspwm_load_i (.aclk(aclk), .meas(meas), .wave_out_a(wa), .wave_out_a_oe(wa_oe),
    .wave_out_b(wb), .wave_out_b_oe(wb_oe), .high_a(high_a), .high_b(high_b));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic int duty(input logic [15:0] c, input logic inv);
    return inv ? 510 - 2 * int'(c) : 2 * int'(c);
  endfunction
  function automatic logic ok_step(input logic [15:0] x, input int dd, pp);
    return (dd == 1 || dd == -1) && int'(x) + dd <= 3 && (pp == dd || pp == 0 || x == 16'h0003 ||
      x == 16'h0000);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    logic ha, hw, hb;
    awaddr <= a;
    wdata <= dat;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    hb = 1'b0;
    while (!hb) begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end
  endtask
  task automatic rdr(input logic [7:0] a);
    logic ha, hr;
    araddr <= a;
    arvalid <= 1'b1;
    hr = 1'b0;
    while (!hr) begin
      @(negedge aclk);
      ha = arvalid && arready;
      if (ha) t_ar = cyc;
      hr = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
    end
  endtask
  task automatic results;
    $display("mismatches %0d, compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial forever #25 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;
  initial begin
    repeat (80000) @(posedge aclk);
    err_total++;
    results();
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 7; i++) begin
      rdr(8'(4 * i));
      `CHK({rs, rd}, {dspwm_pkg::RESP_OKAY, 32'h0})
    end
    rdr(8'h1C);
    `CHK({rs, rd}, {dspwm_pkg::RESP_SLVERR, 32'h0})
    wr(8'h20, 32'hFFFFFFFF);
    `CHK(rs, dspwm_pkg::RESP_SLVERR)
    for (int k = 0; k < 3; k++) begin
      wr(dspwm_pkg::ADDR_CTRL, 32'(k + 1));
      wr(dspwm_pkg::ADDR_CMP_A, 32'hFFFF);
      wr(dspwm_pkg::ADDR_CMP_B, 32'hFFFF);
      rdr(dspwm_pkg::ADDR_CMP_A);
      `CHK(rd, (32'h100 << k) - 32'h1)
      rdr(dspwm_pkg::ADDR_CMP_B);
      `CHK(rd, (32'h100 << k) - 32'h1)
    end
    wr(dspwm_pkg::ADDR_CAP, 32'hFFFF);
    foreach (dv[i]) begin
      wr(dspwm_pkg::ADDR_CTRL, {21'h0, 3'(i + 1), 8'h08});
      wr(dspwm_pkg::ADDR_COUNT, 32'h0);
      rdr(dspwm_pkg::ADDR_COUNT);
      v = rd[15:0];
      t0 = t_ar;
      repeat (1030) @(posedge aclk);
      rdr(dspwm_pkg::ADDR_COUNT);
      d = (t_ar - t0) / dv[i];
      pd = int'(rd[15:0]) - int'(v);
      `CHK(pd >= d - 1 && pd <= d + 1, 1'b1)
    end
    foreach (md[i]) begin
      wr(dspwm_pkg::ADDR_CMP_A, 32'h3);
      wr(dspwm_pkg::ADDR_CMP_B, 32'h2);
      wr(dspwm_pkg::ADDR_CAP, 32'h3);
      wr(dspwm_pkg::ADDR_CTRL, {21'h0, dspwm_pkg::PRESC_64, 4'h0, md[i]});
      wr(dspwm_pkg::ADDR_COUNT, 32'h0);
      repeat (800) @(posedge aclk);
      rdr(dspwm_pkg::ADDR_COUNT);
      v = rd[15:0];
      run = 0;
      pd = 0;
      repeat (600) begin
        rdr(dspwm_pkg::ADDR_COUNT);
        d = int'(rd[15:0]) - int'(v);
        run = d == 0 ? run + 1 : 0;
        if (d != 0) `CHK(ok_step(v, d, pd), 1'b1)
        if (d != 0) pd = d;
        v = rd[15:0];
        `CHK(run < 40, 1'b1)
      end
      wr(dspwm_pkg::ADDR_CTRL, {24'h0, 4'h0, md[i]});
      wr(dspwm_pkg::ADDR_FLAGS, 32'hF);
      rdr(dspwm_pkg::ADDR_FLAGS);
      `CHK(rd, 32'h0)
      wr(dspwm_pkg::ADDR_CTRL, {21'h0, dspwm_pkg::PRESC_64, 4'h0, md[i]});
      repeat (800) @(posedge aclk);
      rdr(dspwm_pkg::ADDR_FLAGS);
      `CHK(rd, {28'h0, ~md[i][0], 3'h7})
    end
    wr(dspwm_pkg::ADDR_CTRL, {21'h0, dspwm_pkg::PRESC_1, 8'hA1});
    for (int p = 0; p < 16; p++) begin
      wr(dspwm_pkg::ADDR_PINS, 32'(p));
      `CHK({wa_oe, wb_oe}, {p[0] & p[2], p[1] & p[3]})
    end
    for (int k = 0; k < 8; k++) begin
      rnd = lfsr(rnd);
      ca = k == 0 ? 16'h0000 : k == 1 ? dspwm_pkg::TOP_8BIT : {8'h00, rnd[7:0]};
      cb = {8'h00, rnd[15:8]};
      wr(dspwm_pkg::ADDR_CMP_A, {16'h0, ca});
      wr(dspwm_pkg::ADDR_CMP_B, {16'h0, cb});
      wr(dspwm_pkg::ADDR_CTRL, {24'h1, 1'b1, ~k[0], 1'b1, k[0], 4'h1});
      repeat (1100) @(posedge aclk);
      meas <= 1'b1;
      repeat (510) @(posedge aclk);
      meas <= 1'b0;
      @(negedge aclk);
      `CHK(high_a - duty(ca, k[0]) inside {[-2:2]}, 1'b1)
      `CHK(high_b - duty(cb, ~k[0]) inside {[-2:2]}, 1'b1)
      @(posedge aclk);
    end
    results();
  end
endmodule // dspwm_timer_tb
